// ==== core/peripheral_clock_gating.sv ====
// How it works
// R1 - system branch enable is always high
// R2 - gate bit 0 reads one, ignores writes
// R3 - bit 1 gates boot ROM, resets one
// R4 - bit 2 gates on-chip RAM, resets one
// R5 - bit 3 gates flash register interface, resets one
// R6 - bit 4 gates flash array reads, resets one
// R7 - bit 6 gates GPIO, resets one
// R8 - bits 7 to 10 gate timers, reset zero
// R9 - bit 11 gates serial peripheral registers, resets one
// R10 - bit 12 gates UART, resets zero
// R11 - software maps UART pins before enabling UART
// R12 - bit 13 gates ADC, resets zero
// R13 - bit 15 gates watchdog registers, resets zero
// R14 - bit 16 gates pin configuration block, resets zero
// R15 - divider zero stops serial peripheral clock
// R16 - divider 1..255 divides main clock, resets zero
// R17 - reserved bits read zero, ignore writes
// R18 - gating and divider changes stay glitch free
`timescale 1ns/100ps
`default_nettype none

module peripheral_clock_gating
    import clock_gating_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST,
    // AXI4-Lite write address
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] AWADDR,
    input  wire logic [2:0]  AWPROT,
    // AXI4-Lite write data
    input  wire logic        WVALID,
    output logic             WREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    // AXI4-Lite write response
    output logic             BVALID,
    input  wire logic        BREADY,
    output logic [1:0]       BRESP,
    // AXI4-Lite read address
    input  wire logic        ARVALID,
    output logic             ARREADY,
    input  wire logic [31:0] ARADDR,
    input  wire logic [2:0]  ARPROT,
    // AXI4-Lite read data
    output logic             RVALID,
    input  wire logic        RREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    // branch clock enables
    output logic             SYS_CLOCK_ENABLE,
    output logic             ROM_CLOCK_ENABLE,
    output logic             RAM_CLOCK_ENABLE,
    output logic             FLASH_REGIF_CLOCK_ENABLE,
    output logic             FLASH_ARRAY_CLOCK_ENABLE,
    output logic             GPIO_CLOCK_ENABLE,
    output logic             SHORT_TIMER_A_ENABLE,
    output logic             SHORT_TIMER_B_ENABLE,
    output logic             LONG_TIMER_A_ENABLE,
    output logic             LONG_TIMER_B_ENABLE,
    output logic             SERIAL_PERIPH_CLOCK_ENABLE,
    output logic             UART_CLOCK_ENABLE,
    output logic             ADC_CLOCK_ENABLE,
    output logic             WDT_CLOCK_ENABLE,
    output logic             PIN_CONFIG_BLOCK_ENABLE,
    // divided serial peripheral clock, one-cycle pulse per period
    output logic             SERIAL_PERIPH_CLOCK,
    output logic             SERIAL_PERIPH_CLOCK_RUNNING
);

    // =====================================================
    // write channel holding
    logic        aw_full_q;
    logic        aw_full_d;
    logic [31:0] aw_addr_q;
    logic        w_full_q;
    logic        w_full_d;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        bvalid_q;
    logic        bvalid_d;
    logic [1:0]  bresp_q;

    wire         aw_take    = AWVALID && AWREADY;
    wire         w_take     = WVALID && WREADY;
    wire         do_write   = aw_full_q && w_full_q && !bvalid_q;
    wire         wr_gate    = do_write && (aw_addr_q == GATE_ADDR);
    wire         wr_div     = do_write && (aw_addr_q == DIVIDER_ADDR);
    wire         wr_ro      = do_write && (aw_addr_q == DIV_STATUS_ADDR);
    wire         wr_mapped  = wr_gate || wr_div || wr_ro;

    // address and data are taken in either order, one slot each
    assign AWREADY  = !aw_full_q;
    assign WREADY   = !w_full_q;
    assign BVALID   = bvalid_q;
    assign BRESP    = bresp_q;

    // a taken pair waits while the response is pending,
    // so at most one write is in flight
    assign aw_full_d = (aw_full_q || aw_take) && !do_write;
    assign w_full_d  = (w_full_q || w_take) && !do_write;
    assign bvalid_d  = do_write || (bvalid_q && !BREADY);

    always_ff @(posedge CLK) begin
        if (RST) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            aw_addr_q <= 32'h00000000;
            w_data_q  <= 32'h00000000;
            w_strb_q  <= 4'h0;
        end else begin
            aw_full_q <= aw_full_d;
            w_full_q  <= w_full_d;
            bvalid_q  <= bvalid_d;
            if (aw_take) begin
                aw_addr_q <= AWADDR;
            end
            if (w_take) begin
                w_data_q <= WDATA;
                w_strb_q <= WSTRB;
            end
            if (do_write) begin
                bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // =====================================================
    // byte strobes to a bit mask
    logic [31:0] strb_mask;

    for (genvar b = 0; b < 4; b++) begin : g_strb
        assign strb_mask[8*b +: 8] = {8{w_strb_q[b]}};
    end

    // =====================================================
    // gate register
    logic [31:0] gate_q;
    logic [31:0] gate_d;
    logic [31:0] gate_merged;

    assign gate_merged = (gate_q & ~strb_mask) | (w_data_q & strb_mask);
    // writable bits only, bit 0 forced high
    assign gate_d = (gate_merged & GATE_WRITABLE) | GATE_FORCED_ONE; // see R2 see R17

    always_ff @(posedge CLK) begin
        if (RST) begin
            gate_q <= GATE_RESET; // see R3 see R4 see R5 see R6 see R7 see R8
        end else if (wr_gate) begin
            gate_q <= gate_d; // see R10 see R12 see R13 see R14
        end
    end

    // enables leave flops, so a gated branch changes only
    // on a clock edge and never glitches
    assign SYS_CLOCK_ENABLE           = 1'b1;                   // see R1
    assign ROM_CLOCK_ENABLE           = gate_q[ROM_BIT];         // see R3 see R18
    assign RAM_CLOCK_ENABLE           = gate_q[RAM_BIT];         // see R4
    assign FLASH_REGIF_CLOCK_ENABLE   = gate_q[FLASH_REGIF_BIT]; // see R5
    assign FLASH_ARRAY_CLOCK_ENABLE   = gate_q[FLASH_ARRAY_BIT]; // see R6
    assign GPIO_CLOCK_ENABLE          = gate_q[GPIO_BIT];        // see R7
    assign SHORT_TIMER_A_ENABLE       = gate_q[SHORT_A_BIT];     // see R8
    assign SHORT_TIMER_B_ENABLE       = gate_q[SHORT_B_BIT];     // see R8
    assign LONG_TIMER_A_ENABLE        = gate_q[LONG_A_BIT];      // see R8
    assign LONG_TIMER_B_ENABLE        = gate_q[LONG_B_BIT];      // see R8
    assign SERIAL_PERIPH_CLOCK_ENABLE = gate_q[SERIAL_BIT];      // see R9
    // pin mapping order is up to software; not checked here
    assign UART_CLOCK_ENABLE          = gate_q[UART_BIT];        // see R10 see R11
    assign ADC_CLOCK_ENABLE           = gate_q[ADC_BIT];         // see R12
    assign WDT_CLOCK_ENABLE           = gate_q[WDT_BIT];         // see R13
    assign PIN_CONFIG_BLOCK_ENABLE    = gate_q[PIN_CONFIG_BIT];  // see R14

    // =====================================================
    // divider register
    logic [7:0] div_q;
    logic [7:0] div_d;

    assign div_d = strb_mask[0] ? w_data_q[7:0] : div_q; // see R17

    always_ff @(posedge CLK) begin
        if (RST) begin
            div_q <= DIV_RESET; // see R16
        end else if (wr_div) begin
            div_q <= div_d;
        end
    end

    // =====================================================
    // serial peripheral clock divider
    // a new divisor is picked up only at a period boundary,
    // so no shortened period follows a rewrite
    div_state_e  div_state_q;
    div_state_e  div_state_d;
    logic [7:0]  active_q;
    logic [7:0]  active_d;
    logic [7:0]  count_q;
    logic [7:0]  count_d;
    logic        pulse_q;

    // a divisor of one keeps period_end true, so the
    // pulse output then stays high every cycle
    wire        field_zero  = (div_q == DIV_OFF_VALUE);
    wire [7:0]  last_count  = active_q - 8'h01;
    wire        period_end  = (div_state_q == DIV_RUNNING) && (count_q == last_count);
    wire        start_run   = (div_state_q == DIV_STOPPED) && !field_zero;

    always_comb begin
        div_state_d = div_state_q;
        active_d    = active_q;
        count_d     = count_q;
        unique case (div_state_q)
            DIV_STOPPED: begin
                count_d = 8'h00;
                if (!field_zero) begin
                    div_state_d = DIV_RUNNING;
                    active_d    = div_q;
                end
            end
            DIV_RUNNING: begin
                if (period_end) begin
                    count_d  = 8'h00;
                    active_d = div_q; // see R18
                    if (field_zero) begin
                        div_state_d = DIV_STOPPED; // see R15
                    end
                end else begin
                    count_d = count_q + 8'h01;
                end
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            div_state_q <= DIV_STOPPED; // see R16
            active_q    <= DIV_RESET;
            count_q     <= 8'h00;
            pulse_q     <= 1'b0;
        end else begin
            div_state_q <= div_state_d;
            active_q    <= active_d;
            count_q     <= count_d;
            pulse_q     <= period_end; // see R16
        end
    end

    assign SERIAL_PERIPH_CLOCK         = pulse_q;
    assign SERIAL_PERIPH_CLOCK_RUNNING = (div_state_q == DIV_RUNNING);

    // =====================================================
    // read channel
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic [31:0] rd_value;
    logic        rd_hit;

    wire         ar_take     = ARVALID && ARREADY;
    wire         rd_gate     = (ARADDR == GATE_ADDR);
    wire         rd_div      = (ARADDR == DIVIDER_ADDR);
    wire         rd_status   = (ARADDR == DIV_STATUS_ADDR);
    // status word: running flag above the active divisor
    wire [31:0]  status_word = {23'h000000, SERIAL_PERIPH_CLOCK_RUNNING, active_q};

    assign rd_hit   = rd_gate || rd_div || rd_status;
    assign rd_value = rd_gate   ? gate_q :
                      rd_div    ? {24'h000000, div_q} : // see R17
                      rd_status ? status_word :
                                  READ_ZERO;

    // read data is captured at the address handshake, so a
    // later register write never alters a pending answer
    assign ARREADY = !rvalid_q;
    assign RVALID  = rvalid_q;
    assign RDATA   = rdata_q;
    assign RRESP   = rresp_q;

    always_ff @(posedge CLK) begin
        if (RST) begin
            rvalid_q <= 1'b0;
            rdata_q  <= READ_ZERO;
            rresp_q  <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_value;
            rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (RREADY) begin
            rvalid_q <= 1'b0;
        end
    end

    // protection bits carry no meaning for this block
    wire unused_prot = ^{AWPROT, ARPROT};

endmodule : peripheral_clock_gating

`default_nettype wire

// ==== common/clock_gating_pkg.sv ====
`default_nettype none

package clock_gating_pkg;

    // =====================================================
    // register map
    localparam logic [31:0] GATE_ADDR        = 32'h40048080;
    localparam logic [31:0] DIVIDER_ADDR     = 32'h40048094;
    localparam logic [31:0] DIV_STATUS_ADDR  = 32'h400480F0;

    // =====================================================
    // gate register fields
    localparam int          SYS_BIT          = 0;
    localparam int          ROM_BIT          = 1;
    localparam int          RAM_BIT          = 2;
    localparam int          FLASH_REGIF_BIT  = 3;
    localparam int          FLASH_ARRAY_BIT  = 4;
    localparam int          GPIO_BIT         = 6;
    localparam int          SHORT_A_BIT      = 7;
    localparam int          SHORT_B_BIT      = 8;
    localparam int          LONG_A_BIT       = 9;
    localparam int          LONG_B_BIT       = 10;
    localparam int          SERIAL_BIT       = 11;
    localparam int          UART_BIT         = 12;
    localparam int          ADC_BIT          = 13;
    localparam int          WDT_BIT          = 15;
    localparam int          PIN_CONFIG_BIT   = 16;
    localparam logic [31:0] GATE_WRITABLE    = 32'h0001BFDE;
    localparam logic [31:0] GATE_FORCED_ONE  = 32'h00000001;
    localparam logic [31:0] GATE_RESET       = 32'h0000085F;

    // =====================================================
    // divider fields
    localparam int          DIV_W            = 8;
    localparam logic [7:0]  DIV_RESET        = 8'h00;
    localparam logic [7:0]  DIV_OFF_VALUE    = 8'h00;
    localparam int          DIV_RUN_BIT      = 8;

    // =====================================================
    // bus answers
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;
    localparam logic [31:0] READ_ZERO        = 32'h00000000;

    typedef enum logic {
        DIV_STOPPED,
        DIV_RUNNING
    } div_state_e;

endpackage : clock_gating_pkg

`default_nettype wire

// ==== bench/peripheral_clock_gating_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
module peripheral_clock_gating_sva (
    input wire logic        CLK,
    input wire logic        RST,
    input wire logic        ARVALID,
    input wire logic        ARREADY,
    input wire logic        RVALID,
    input wire logic        RREADY,
    input wire logic [31:0] RDATA,
    input wire logic        BVALID,
    input wire logic        BREADY,
    input wire logic [1:0]  BRESP,
    input wire logic        SYS_CLOCK_ENABLE,
    input wire logic        ROM_CLOCK_ENABLE,
    input wire logic        UART_CLOCK_ENABLE,
    input wire logic        SERIAL_PERIPH_CLOCK,
    input wire logic        SERIAL_PERIPH_CLOCK_RUNNING
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // =====================================
    // assertions
    AST_SYS_ON: assert property (SYS_CLOCK_ENABLE)
        else $error("system branch enable low");
    AST_RST_VAL: assert property ($fell(RST) |-> ROM_CLOCK_ENABLE && !UART_CLOCK_ENABLE
        && !SERIAL_PERIPH_CLOCK_RUNNING) else $error("bad values after reset");
    AST_STOP_QUIET: assert property (!SERIAL_PERIPH_CLOCK_RUNNING[*2] |-> !SERIAL_PERIPH_CLOCK)
        else $error("pulse while divider stopped");
    AST_START_GAP: assert property ($rose(SERIAL_PERIPH_CLOCK_RUNNING) |-> !SERIAL_PERIPH_CLOCK)
        else $error("pulse at divider start");
    AST_PULSE_RUN: assert property ($rose(SERIAL_PERIPH_CLOCK) |-> $past(SERIAL_PERIPH_CLOCK_RUNNING))
        else $error("pulse without running divider");
    // enables only move with a completed write, never on their own
    AST_EN_BY_WRITE: assert property ($changed({ROM_CLOCK_ENABLE, UART_CLOCK_ENABLE})
        |-> $rose(BVALID)) else $error("enable changed without write");
    AST_READ_LAT: assert property (ARVALID && ARREADY |=> RVALID)
        else $error("read answer late");
    AST_READ_HOLD: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read data not held");
    AST_WRITE_HOLD: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write response not held");
    AST_AR_BLOCK: assert property (RVALID |-> !ARREADY)
        else $error("read address taken while busy");
    CV_READ_WAIT: cover property (RVALID && !RREADY);
    CV_DIV_START: cover property ($rose(SERIAL_PERIPH_CLOCK_RUNNING));
    CV_DIV_STOP: cover property ($fell(SERIAL_PERIPH_CLOCK_RUNNING));
endmodule : peripheral_clock_gating_sva
bind peripheral_clock_gating peripheral_clock_gating_sva peripheral_clock_gating_sva_i (.*);
`default_nettype wire

// ==== bench/peripheral_clock_gating_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module peripheral_clock_gating_tb;
    import clock_gating_pkg::*;
    logic        CLK, RST, AWVALID, WVALID, BREADY, ARVALID, RREADY;
    logic        AWREADY, WREADY, BVALID, ARREADY, RVALID;
    logic [31:0] AWADDR, WDATA, ARADDR, RDATA, rd_data, en_map;
    logic [3:0]  WSTRB;
    logic [2:0]  AWPROT, ARPROT;
    logic [1:0]  BRESP, RRESP, rsp;
    logic SYS_CLOCK_ENABLE, ROM_CLOCK_ENABLE, RAM_CLOCK_ENABLE, FLASH_REGIF_CLOCK_ENABLE;
    logic FLASH_ARRAY_CLOCK_ENABLE, GPIO_CLOCK_ENABLE, SHORT_TIMER_A_ENABLE, SHORT_TIMER_B_ENABLE;
    logic LONG_TIMER_A_ENABLE, LONG_TIMER_B_ENABLE, SERIAL_PERIPH_CLOCK_ENABLE, UART_CLOCK_ENABLE;
    logic ADC_CLOCK_ENABLE, WDT_CLOCK_ENABLE, PIN_CONFIG_BLOCK_ENABLE;
    logic SERIAL_PERIPH_CLOCK, SERIAL_PERIPH_CLOCK_RUNNING;
    int   errors, samples_checked, n, k;
    // first write opens the pin configuration clock, the next one the UART
    logic [31:0] wd[3] = '{32'h00010000, 32'hFFFFFFFF, 32'h00000000};
    logic [3:0]  sb[3] = '{4'hF, 4'hF, 4'h1};
    logic [31:0] ge[3] = '{32'h00010001, 32'h0001BFDF, 32'h0001BF01};
    logic [7:0]  dv[4] = '{8'h01, 8'h02, 8'h03, 8'hFF};

    // enable pins laid out as the gate register bits
    assign en_map = {15'h0, PIN_CONFIG_BLOCK_ENABLE, WDT_CLOCK_ENABLE, 1'b0, ADC_CLOCK_ENABLE,
        UART_CLOCK_ENABLE, SERIAL_PERIPH_CLOCK_ENABLE, LONG_TIMER_B_ENABLE, LONG_TIMER_A_ENABLE,
        SHORT_TIMER_B_ENABLE, SHORT_TIMER_A_ENABLE, GPIO_CLOCK_ENABLE, 1'b0,
        FLASH_ARRAY_CLOCK_ENABLE, FLASH_REGIF_CLOCK_ENABLE, RAM_CLOCK_ENABLE, ROM_CLOCK_ENABLE,
        SYS_CLOCK_ENABLE};

    peripheral_clock_gating peripheral_clock_gating_i (.*);

    initial begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end

    task automatic test_done;
        $display("checked %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : test_done

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic give_up(input int c);
        if (c >= 600) begin
            errors++;
            test_done();
        end
    endtask : give_up

    // all bus tasks start and end right after a rising edge
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
        int c;
        AWADDR <= a;
        WDATA <= d;
        WSTRB <= s;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        c = 0;
        do begin
            @(posedge CLK);
            c++;
            if (AWREADY) AWVALID <= 1'b0;
            if (WREADY) WVALID <= 1'b0;
        end while (BVALID !== 1'b1 && c < 600);
        give_up(c);
        BREADY <= 1'b1;
        @(posedge CLK);
        BREADY <= 1'b0;
        rsp = BRESP;
    endtask : wr

    task automatic rd(input logic [31:0] a);
        int c;
        ARADDR <= a;
        ARVALID <= 1'b1;
        c = 0;
        do begin
            @(posedge CLK);
            c++;
            if (ARREADY) ARVALID <= 1'b0;
        end while (RVALID !== 1'b1 && c < 600);
        give_up(c);
        RREADY <= 1'b1;
        @(posedge CLK);
        RREADY <= 1'b0;
        rd_data = RDATA;
        rsp = RRESP;
    endtask : rd

    // first gap may span a divisor change, so the third is measured
    task automatic period(input logic [7:0] div);
        int c;
        for (int i = 0; i < 3; i++) begin
            c = 0;
            do begin
                @(posedge CLK);
                c++;
            end while (SERIAL_PERIPH_CLOCK !== 1'b1 && c < 600);
            give_up(c);
        end
        check("pulse spacing", {24'h0, div}, 32'(c));
    endtask : period

    initial begin
        {RST, AWVALID, WVALID, BREADY, ARVALID, RREADY} = 6'h20;
        {AWADDR, WDATA, ARADDR, WSTRB, AWPROT, ARPROT} = '0;
        errors = 0;
        samples_checked = 0;
        repeat (12) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        check("enables", 32'h0000085F, en_map);
        rd(GATE_ADDR);
        check("gate", 32'h0000085F, rd_data);
        rd(DIVIDER_ADDR);
        check("divider", 32'h00000000, rd_data);
        for (n = 0; n < 3; n++) begin
            wr(GATE_ADDR, wd[n], sb[n]);
            check("bresp", 32'h0, {30'h0, rsp});
            rd(GATE_ADDR);
            check("gate", ge[n], rd_data);
            check("enables", ge[n], en_map);
        end
        wr(32'h40048084, 32'hFFFFFFFF, 4'hF);
        check("bresp", 32'h2, {30'h0, rsp});
        rd(32'h40048084);
        check("rresp", 32'h2, {30'h0, rsp});
        check("unmapped", 32'h0, rd_data);
        for (n = 0; n < 4; n++) begin
            wr(DIVIDER_ADDR, {24'hFFFFFF, dv[n]}, 4'hF);
            rd(DIVIDER_ADDR);
            check("divider", {24'h0, dv[n]}, rd_data);
            period(dv[n]);
        end
        wr(DIV_STATUS_ADDR, 32'h0, 4'hF);
        check("bresp", 32'h0, {30'h0, rsp});
        rd(DIV_STATUS_ADDR);
        check("status", 32'h000001FF, rd_data);
        wr(DIVIDER_ADDR, 32'h0, 4'hF);
        repeat (300) @(posedge CLK);
        k = 0;
        repeat (300) begin
            @(posedge CLK);
            if (SERIAL_PERIPH_CLOCK !== 1'b0) k++;
        end
        check("stopped pulses", 32'h0, 32'(k));
        check("running", 32'h0, {31'h0, SERIAL_PERIPH_CLOCK_RUNNING});
        wr(DIVIDER_ADDR, 32'h3, 4'hF);
        RST <= 1'b1;
        repeat (3) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        check("enables", 32'h0000085F, en_map);
        check("running", 32'h0, {31'h0, SERIAL_PERIPH_CLOCK_RUNNING});
        rd(DIVIDER_ADDR);
        check("divider", 32'h0, rd_data);
        test_done();
    end
endmodule : peripheral_clock_gating_tb
`default_nettype wire
